// ==== supply_seq_pkg.sv ====
// constants, types and register map of the supply output sequencer
package supply_seq_pkg;

  // ==========================================================================
  // time base
  localparam int unsigned CLK_FREQ_HZ = 200_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CYCLES_PER_MS = CLK_FREQ_HZ / MS_PER_S;

  // ==========================================================================
  // sequencing times, all in milliseconds
  localparam int MS_W = 12;
  typedef logic [MS_W-1:0] ms_t;
  localparam ms_t MS_ZERO = 12'h000;
  localparam ms_t MS_ONE = 12'h001;
  localparam ms_t LG_ON_FIRST_MS = 12'h0c8;
  localparam ms_t LG_ON_DIP_MS = 12'h032;
  localparam ms_t LG_OFF_MS = 12'h002;
  localparam ms_t MAIN_ON_DLY_MS = 12'h014;
  localparam ms_t PG_ON_DLY_MS = 12'h096;
  localparam ms_t OFF_DLY_SLOW_MS = 12'h014;
  localparam ms_t OFF_DLY_OC_MS = 12'h00a;
  localparam ms_t OFF_DLY_LINE_MS = 12'h008;
  localparam ms_t SB_HOLD_MS = 12'h010;
  localparam ms_t MIN_OFF_MS = 12'h3e8;

  // ==========================================================================
  // main rail sequencing states
  typedef enum logic [4:0] {
    ST_IDLE     = 5'h01,
    ST_ON_DLY   = 5'h02,
    ST_MAIN_ON  = 5'h04,
    ST_OFF_DLY  = 5'h08,
    ST_OFF_HOLD = 5'h10
  } main_st_t;

  // ==========================================================================
  // register map
  localparam int AXI_ADDR_W = 4;
  localparam int AXI_DATA_W = 32;
  localparam logic [AXI_ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [AXI_ADDR_W-1:0] STATUS_OFS = 4'h4;
  localparam logic [AXI_ADDR_W-1:0] SHARE_OFS = 4'h8;
  localparam int CTRL_GRANT_BIT = 0;
  localparam logic CTRL_GRANT_RST = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== tick_if.sv ====
// millisecond tick carried from the time base to the sequencer
`timescale 1ns/1ps
interface tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface

// ==== ms_timebase.sv ====
// free-running millisecond time base
`timescale 1ns/1ps
module ms_timebase #(
  parameter int unsigned CYCLES_PER_MS = supply_seq_pkg::CYCLES_PER_MS
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  tick_if.src tb
);

  localparam int CNT_W = $clog2(CYCLES_PER_MS);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CYCLES_PER_MS - 1);

  if (CYCLES_PER_MS < 2)
  begin : g_bad_rate
    $error("ms_timebase needs at least two cycles per tick");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic tick;
  } tb_state_t;

  tb_state_t q;
  tb_state_t n;

  // ==========================================================================
  // counter, cleared at power-up
  always_comb
  begin
    n = q;
    n.tick = (q.cnt == CNT_LAST);
    if (q.cnt == CNT_LAST)
      n.cnt = '0;
    else
      n.cnt = q.cnt + CNT_W'(1);
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      q <= '0;
    else
      q <= n;
  end

  assign tb.tick = q.tick;

endmodule

// ==== supply_output_sequencer.sv ====
// sequencer for standby and main rails, status flags and share bus
`timescale 1ns/1ps
module supply_output_sequencer #(
  parameter int unsigned CYCLES_PER_MS = supply_seq_pkg::CYCLES_PER_MS,
  parameter int SHARE_W = 8,
  parameter int TRIM_W = 4,
  parameter int TRIM_MAX = 10
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic line_in_range_i,
  input wire logic main_output_enable_n_i,
  input wire logic hot_unplug_kill_i,
  input wire logic standby_rail_ok_i,
  input wire logic main_rail_above_thr_i,
  input wire logic fan_fail_i,
  input wire logic over_temp_i,
  input wire logic standby_uv_ov_i,
  input wire logic main_over_current_i,
  input wire logic main_short_i,
  input wire logic main_over_voltage_i,
  input wire logic load_low_i,
  input wire logic [SHARE_W-1:0] load_current_i,
  input wire logic standby_permit_line_i,
  input wire logic share_bus_pin_i,
  input wire logic power_good_flag_i,
  output logic standby_rail_en_o,
  output logic main_rail_en_o,
  output logic dcdc_standby_o,
  output logic line_good_flag_o,
  output logic power_good_flag_o,
  output logic power_good_flag_oe_n_o,
  output logic standby_permit_line_o,
  output logic standby_permit_line_oe_n_o,
  output logic share_bus_pin_o,
  output logic share_bus_pin_oe_n_o,
  output logic share_master_o,
  output logic [TRIM_W-1:0] share_trim_o,
  output logic fault_latched_o,
  input wire logic [supply_seq_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [supply_seq_pkg::AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [supply_seq_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [supply_seq_pkg::AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int SB_W = $clog2(SHARE_W);
  localparam int AW = supply_seq_pkg::AXI_ADDR_W;
  localparam int DW = supply_seq_pkg::AXI_DATA_W;
  localparam logic [SB_W-1:0] SH_LAST = SB_W'(SHARE_W - 1);
  localparam logic [TRIM_W-1:0] TRIM_TOP = TRIM_W'(TRIM_MAX);

  if (SHARE_W < 2 || TRIM_W < 1 || TRIM_MAX < 1 || TRIM_MAX >= 2**TRIM_W)
  begin : g_bad_param
    $error("supply_output_sequencer share or trim width out of range");
  end

  typedef struct packed {
    supply_seq_pkg::main_st_t st;
    supply_seq_pkg::ms_t main_tmr;
    supply_seq_pkg::ms_t off_lim;
    supply_seq_pkg::ms_t lg_tmr;
    supply_seq_pkg::ms_t sb_tmr;
    supply_seq_pkg::ms_t pg_tmr;
    logic main_en;
    logic lg;
    logic lg_seen;
    logic sb_en;
    logic sb_hold;
    logic pg;
    logic fault;
    logic hs;
    logic grant;
    logic [SHARE_W-1:0] sh_word;
    logic [SB_W-1:0] sh_bit;
    logic sh_lost;
    logic sh_drive;
    logic master;
    logic [TRIM_W-1:0] trim;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [DW-1:0] rdata;
  } seq_state_t;

  seq_state_t q;
  seq_state_t n;

  tick_if tb_if ();
  logic tick;
  logic fault_ev;
  logic hard_kill;
  logic main_go;
  logic line_down;
  logic connected;
  logic lost_now;
  logic [DW-1:0] status_word;
  logic [DW-1:0] share_word;

  ms_timebase #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
  ) u_timebase (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .tb(tb_if.src)
  );

  assign tick = tb_if.tick;
  assign fault_ev = fan_fail_i | over_temp_i | standby_uv_ov_i
                    | main_over_current_i | main_short_i
                    | main_over_voltage_i;
  // these causes cut the rail at once, power-good follows the rail
  assign hard_kill = hot_unplug_kill_i | main_short_i | main_over_voltage_i;
  assign status_word = DW'({q.hs, q.master, q.fault, power_good_flag_i,
                            q.pg, q.lg, q.sb_en, q.main_en, q.st});
  assign share_word = DW'({q.master, q.trim});

  // ==========================================================================
  // next state
  always_comb
  begin
    n = q;
    main_go = 1'b0;
    line_down = 1'b0;
    connected = 1'b0;
    lost_now = 1'b0;

    // fault latch; a new event wins over the clear
    n.fault = fault_ev | (q.fault & ~main_output_enable_n_i);

    // line-good flag, timed on ms ticks
    if (line_in_range_i != q.lg)
    begin
      if (tick)
        n.lg_tmr = q.lg_tmr + supply_seq_pkg::MS_ONE;
    end
    else
      n.lg_tmr = supply_seq_pkg::MS_ZERO;
    if (!q.lg && line_in_range_i && q.lg_tmr >= (q.lg_seen
        ? supply_seq_pkg::LG_ON_DIP_MS : supply_seq_pkg::LG_ON_FIRST_MS))
    begin
      n.lg = 1'b1;
      n.lg_seen = 1'b1;
      n.lg_tmr = supply_seq_pkg::MS_ZERO;
    end
    if (q.lg && !line_in_range_i && q.lg_tmr >= supply_seq_pkg::LG_OFF_MS)
    begin
      n.lg = 1'b0;
      n.lg_tmr = supply_seq_pkg::MS_ZERO;
    end
    line_down = !n.lg && !line_in_range_i;

    // standby rail: holds past line-good, then rests before restart
    if (q.sb_en)
    begin
      if (line_down)
      begin
        if (tick)
          n.sb_tmr = q.sb_tmr + supply_seq_pkg::MS_ONE;
        if (q.sb_tmr >= supply_seq_pkg::SB_HOLD_MS)
        begin
          n.sb_en = 1'b0;
          n.sb_hold = 1'b1;
          n.sb_tmr = supply_seq_pkg::MS_ZERO;
        end
      end
      else
        n.sb_tmr = supply_seq_pkg::MS_ZERO;
    end
    else if (q.sb_hold)
    begin
      if (tick)
        n.sb_tmr = q.sb_tmr + supply_seq_pkg::MS_ONE;
      if (q.sb_tmr >= supply_seq_pkg::MIN_OFF_MS)
      begin
        n.sb_hold = 1'b0;
        n.sb_tmr = supply_seq_pkg::MS_ZERO;
      end
    end
    else if (line_in_range_i)
      n.sb_en = 1'b1;

    // main rail sequencing
    main_go = q.sb_en && standby_rail_ok_i && !main_output_enable_n_i
              && !n.fault && !hot_unplug_kill_i && line_in_range_i;
    case (q.st)
      supply_seq_pkg::ST_IDLE:
      begin
        n.main_tmr = supply_seq_pkg::MS_ZERO;
        if (main_go)
          n.st = supply_seq_pkg::ST_ON_DLY;
      end
      supply_seq_pkg::ST_ON_DLY:
      begin
        if (!main_go)
          n.st = supply_seq_pkg::ST_IDLE;
        else
        begin
          if (tick)
            n.main_tmr = q.main_tmr + supply_seq_pkg::MS_ONE;
          if (q.main_tmr >= supply_seq_pkg::MAIN_ON_DLY_MS)
          begin
            n.st = supply_seq_pkg::ST_MAIN_ON;
            n.main_tmr = supply_seq_pkg::MS_ZERO;
          end
        end
      end
      supply_seq_pkg::ST_MAIN_ON:
      begin
        n.main_tmr = supply_seq_pkg::MS_ZERO;
        if (hard_kill)
          n.st = supply_seq_pkg::ST_OFF_HOLD;
        else if (line_down)
        begin
          n.st = supply_seq_pkg::ST_OFF_DLY;
          n.off_lim = supply_seq_pkg::OFF_DLY_LINE_MS;
        end
        else if (main_over_current_i)
        begin
          n.st = supply_seq_pkg::ST_OFF_DLY;
          n.off_lim = supply_seq_pkg::OFF_DLY_OC_MS;
        end
        else if (main_output_enable_n_i || fan_fail_i || over_temp_i
                 || standby_uv_ov_i)
        begin
          n.st = supply_seq_pkg::ST_OFF_DLY;
          n.off_lim = supply_seq_pkg::OFF_DLY_SLOW_MS;
        end
      end
      supply_seq_pkg::ST_OFF_DLY:
      begin
        // power-good is already down here, the rail follows
        if (hard_kill)
        begin
          n.st = supply_seq_pkg::ST_OFF_HOLD;
          n.main_tmr = supply_seq_pkg::MS_ZERO;
        end
        else
        begin
          if (tick)
            n.main_tmr = q.main_tmr + supply_seq_pkg::MS_ONE;
          if (q.main_tmr >= q.off_lim)
          begin
            n.st = supply_seq_pkg::ST_OFF_HOLD;
            n.main_tmr = supply_seq_pkg::MS_ZERO;
          end
        end
      end
      supply_seq_pkg::ST_OFF_HOLD:
      begin
        // rest wins over a quick re-enable: a late restart is safer
        if (tick)
          n.main_tmr = q.main_tmr + supply_seq_pkg::MS_ONE;
        if (q.main_tmr >= supply_seq_pkg::MIN_OFF_MS)
        begin
          n.st = supply_seq_pkg::ST_IDLE;
          n.main_tmr = supply_seq_pkg::MS_ZERO;
        end
      end
      default:
      begin
        n.st = supply_seq_pkg::ST_IDLE;
        n.main_tmr = supply_seq_pkg::MS_ZERO;
      end
    endcase
    n.main_en = (n.st == supply_seq_pkg::ST_MAIN_ON)
                || (n.st == supply_seq_pkg::ST_OFF_DLY);

    // power-good
    if (n.st == supply_seq_pkg::ST_MAIN_ON && standby_rail_ok_i
        && main_rail_above_thr_i)
    begin
      if (tick && q.pg_tmr < supply_seq_pkg::PG_ON_DLY_MS)
        n.pg_tmr = q.pg_tmr + supply_seq_pkg::MS_ONE;
    end
    else
      n.pg_tmr = supply_seq_pkg::MS_ZERO;
    n.pg = (n.st == supply_seq_pkg::ST_MAIN_ON) && standby_rail_ok_i
           && main_rail_above_thr_i
           && q.pg_tmr >= supply_seq_pkg::PG_ON_DLY_MS;

    // hot standby drops the moment any permission goes away
    n.hs = standby_permit_line_i && load_low_i && q.grant && !n.fault
           && n.st == supply_seq_pkg::ST_MAIN_ON;

    // share bus arbitration, one bit per ms, value 1 pulls the bus low
    connected = n.main_en && !n.fault && !n.hs;
    if (!connected)
    begin
      n.sh_bit = '0;
      n.sh_lost = 1'b0;
      n.sh_drive = 1'b0;
      n.sh_word = '0;
      n.master = 1'b0;
      n.trim = '0;
    end
    else if (tick)
    begin
      lost_now = q.sh_lost || (!q.sh_drive && !share_bus_pin_i);
      if (q.sh_bit == SH_LAST)
      begin
        n.master = !lost_now;
        if (!lost_now)
          n.trim = '0;
        else if (q.trim < TRIM_TOP)
          n.trim = q.trim + TRIM_W'(1);
        n.sh_bit = '0;
        n.sh_lost = 1'b0;
        n.sh_word = load_current_i;
        n.sh_drive = load_current_i[SHARE_W-1];
      end
      else
      begin
        n.sh_bit = q.sh_bit + SB_W'(1);
        n.sh_lost = lost_now;
        n.sh_word = {q.sh_word[SHARE_W-2:0], 1'b0};
        n.sh_drive = !lost_now && q.sh_word[SHARE_W-2];
      end
    end

    // register bus, write channel
    n.awready = 1'b0;
    n.wready = 1'b0;
    if (!q.awready && !q.bvalid && s_axi_awvalid && s_axi_wvalid)
    begin
      n.awready = 1'b1;
      n.wready = 1'b1;
    end
    if (q.awready)
    begin
      n.bvalid = 1'b1;
      n.bresp = supply_seq_pkg::RESP_OKAY;
      if (s_axi_awaddr[AW-1:2] == supply_seq_pkg::CTRL_OFS[AW-1:2])
      begin
        if (s_axi_wstrb[0])
          n.grant = s_axi_wdata[supply_seq_pkg::CTRL_GRANT_BIT];
      end
      else if (s_axi_awaddr[AW-1:2] != supply_seq_pkg::STATUS_OFS[AW-1:2]
               && s_axi_awaddr[AW-1:2] != supply_seq_pkg::SHARE_OFS[AW-1:2])
        n.bresp = supply_seq_pkg::RESP_SLVERR;
    end
    else if (q.bvalid && s_axi_bready)
      n.bvalid = 1'b0;

    // register bus, read channel
    n.arready = !q.arready && !q.rvalid && s_axi_arvalid;
    if (q.arready)
    begin
      n.rvalid = 1'b1;
      n.rresp = supply_seq_pkg::RESP_OKAY;
      if (s_axi_araddr[AW-1:2] == supply_seq_pkg::CTRL_OFS[AW-1:2])
        n.rdata = DW'(q.grant);
      else if (s_axi_araddr[AW-1:2] == supply_seq_pkg::STATUS_OFS[AW-1:2])
        n.rdata = status_word;
      else if (s_axi_araddr[AW-1:2] == supply_seq_pkg::SHARE_OFS[AW-1:2])
        n.rdata = share_word;
      else
      begin
        n.rdata = '0;
        n.rresp = supply_seq_pkg::RESP_SLVERR;
      end
    end
    else if (q.rvalid && s_axi_rready)
      n.rvalid = 1'b0;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      q <= '0;
      q.st <= supply_seq_pkg::ST_IDLE;
      q.grant <= supply_seq_pkg::CTRL_GRANT_RST;
    end
    else
      q <= n;
  end

  // ==========================================================================
  // outputs, open-drain pins only ever pull low
  assign standby_rail_en_o = q.sb_en;
  assign main_rail_en_o = q.main_en;
  assign dcdc_standby_o = q.hs;
  assign line_good_flag_o = q.lg;
  assign power_good_flag_o = 1'b0;
  assign power_good_flag_oe_n_o = q.pg;
  assign standby_permit_line_o = 1'b0;
  assign standby_permit_line_oe_n_o = !q.fault;
  assign share_bus_pin_o = 1'b0;
  assign share_bus_pin_oe_n_o = !q.sh_drive;
  assign share_master_o = q.master;
  assign share_trim_o = q.trim;
  assign fault_latched_o = q.fault;
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;

  // ==========================================================================
  // checks, with ms counters that only they read
  localparam supply_seq_pkg::ms_t A_SB_MAIN_MIN = 12'h00a;
  localparam supply_seq_pkg::ms_t A_PG_MIN = 12'h064;
  localparam supply_seq_pkg::ms_t A_LG_OFF_MAX = 12'h005;
  supply_seq_pkg::ms_t a_off_ms;
  supply_seq_pkg::ms_t a_sb_ms;
  supply_seq_pkg::ms_t a_on_ms;
  supply_seq_pkg::ms_t a_lgbad_ms;

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      a_off_ms <= supply_seq_pkg::MIN_OFF_MS;
      a_sb_ms <= supply_seq_pkg::MS_ZERO;
      a_on_ms <= supply_seq_pkg::MS_ZERO;
      a_lgbad_ms <= supply_seq_pkg::MS_ZERO;
    end
    else
    begin
      if (main_rail_en_o)
        a_off_ms <= supply_seq_pkg::MS_ZERO;
      else if (tick && a_off_ms < supply_seq_pkg::MIN_OFF_MS)
        a_off_ms <= a_off_ms + supply_seq_pkg::MS_ONE;
      if (!(standby_rail_en_o && standby_rail_ok_i))
        a_sb_ms <= supply_seq_pkg::MS_ZERO;
      else if (tick && a_sb_ms < A_SB_MAIN_MIN)
        a_sb_ms <= a_sb_ms + supply_seq_pkg::MS_ONE;
      if (!main_rail_en_o)
        a_on_ms <= supply_seq_pkg::MS_ZERO;
      else if (tick && a_on_ms < A_PG_MIN)
        a_on_ms <= a_on_ms + supply_seq_pkg::MS_ONE;
      if (!(line_good_flag_o && !line_in_range_i))
        a_lgbad_ms <= supply_seq_pkg::MS_ZERO;
      else if (tick && a_lgbad_ms < A_LG_OFF_MAX)
        a_lgbad_ms <= a_lgbad_ms + supply_seq_pkg::MS_ONE;
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_lg_fall;
    line_good_flag_o ##1 !line_good_flag_o;
  endsequence

  sequence s_main_rise;
    !main_rail_en_o ##1 main_rail_en_o;
  endsequence

  a_kill_main_off: assert property (
    hot_unplug_kill_i && line_in_range_i && standby_rail_en_o
      |=> !main_rail_en_o && standby_rail_en_o)
    else $error("main rail on or standby lost after kill");
  a_share_release: assert property (
    (!main_rail_en_o || fault_latched_o) |-> share_bus_pin_oe_n_o)
    else $error("share pin driven while off or faulted");
  a_pg_rails_ok: assert property (
    power_good_flag_oe_n_o |->
      $past(standby_rail_ok_i) && $past(main_rail_above_thr_i))
    else $error("power-good high without good rails");
  a_pg_on_delay: assert property (
    $rose(power_good_flag_oe_n_o) |-> a_on_ms >= A_PG_MIN)
    else $error("power-good too early after main rail");
  a_lg_off_time: assert property (
    line_good_flag_o |-> a_lgbad_ms < A_LG_OFF_MAX)
    else $error("line-good held too long after line loss");
  a_lg_pg_drop: assert property (
    s_lg_fall |-> !power_good_flag_oe_n_o)
    else $error("power-good still high after line-good fell");
  a_main_after_sb: assert property (
    s_main_rise |-> $past(a_sb_ms) >= A_SB_MAIN_MIN)
    else $error("main rail up too soon after standby");
  a_main_min_off: assert property (
    s_main_rise |-> $past(a_off_ms) >= supply_seq_pkg::MIN_OFF_MS)
    else $error("main rail restarted before off time");
  a_permit_fault: assert property (
    fault_latched_o |-> !standby_permit_line_oe_n_o && !dcdc_standby_o)
    else $error("permit line not pulled low on fault");
  a_hs_enter: assert property (
    $rose(dcdc_standby_o) |->
      $past(standby_permit_line_i) && $past(load_low_i))
    else $error("hot standby without permit and low load");
  a_trim_limit: assert property (
    share_master_o |-> share_trim_o == '0 ##1 share_trim_o <= TRIM_TOP)
    else $error("share trim wrong for master");

endmodule

// ==== supply_far_side.sv ====
// wired bus levels seen by the sequencer, with a peer supply on them
`timescale 1ns/1ps
module supply_far_side (
  input wire logic share_oe_n_i,
  input wire logic permit_oe_n_i,
  input wire logic pg_oe_n_i,
  input wire logic peer_fault_i,
  input wire logic peer_share_i,
  output logic share_lvl_o,
  output logic permit_lvl_o,
  output logic pg_lvl_o
);
  // recessive high, any party pulling low wins
  assign share_lvl_o = share_oe_n_i & ~peer_share_i;
  // faulted peer pulls the permit line low
  assign permit_lvl_o = permit_oe_n_i & ~peer_fault_i;
  // pull-up returns the pin high once released
  assign pg_lvl_o = pg_oe_n_i;
endmodule

// ==== supply_output_sequencer_tb.sv ====
// self-checking bench for the supply output sequencer
`timescale 1ns/1ps
module supply_output_sequencer_tb;
  localparam int CPM = 10;
  localparam logic [3:0] CT = supply_seq_pkg::CTRL_OFS;
  logic sys_clk_i = 0, rst_b_i = 0, line_in_range_i = 0, load_low_i = 0;
  logic main_output_enable_n_i = 1, standby_rail_ok_i = 0, peer_flt = 0;
  logic main_rail_above_thr_i = 0, peer_tx = 0, s_axi_awvalid = 0;
  logic s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, standby_permit_line_i, share_bus_pin_i;
  logic power_good_flag_i, standby_rail_en_o, main_rail_en_o;
  logic dcdc_standby_o, line_good_flag_o, power_good_flag_oe_n_o;
  logic standby_permit_line_oe_n_o, share_bus_pin_oe_n_o;
  logic fault_latched_o, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [6:0] flt = 7'h00;
  logic peer_on = 0, share_master_o;
  logic [3:0] share_trim_o;
  logic [7:0] load_current_i = 8'h00;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'hd9f7ad95;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [33:0] notes[$];
  int miscompares = 0, num_checks = 0;

  supply_output_sequencer #(.CYCLES_PER_MS(CPM)) dut_u (
    .sys_clk_i, .rst_b_i, .line_in_range_i, .main_output_enable_n_i,
    .hot_unplug_kill_i(flt[0]), .standby_rail_ok_i, .main_rail_above_thr_i,
    .fan_fail_i(flt[1]), .over_temp_i(flt[2]), .standby_uv_ov_i(flt[3]),
    .main_over_current_i(flt[4]), .main_short_i(flt[5]),
    .main_over_voltage_i(flt[6]), .load_low_i, .load_current_i,
    .standby_permit_line_i, .share_bus_pin_i, .power_good_flag_i,
    .standby_rail_en_o, .main_rail_en_o, .dcdc_standby_o, .line_good_flag_o,
    .power_good_flag_o(), .power_good_flag_oe_n_o, .standby_permit_line_o(),
    .standby_permit_line_oe_n_o, .share_bus_pin_o(), .share_bus_pin_oe_n_o,
    .share_master_o, .share_trim_o, .fault_latched_o, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  supply_far_side far_u (.share_oe_n_i(share_bus_pin_oe_n_o),
    .permit_oe_n_i(standby_permit_line_oe_n_o),
    .pg_oe_n_i(power_good_flag_oe_n_o), .peer_fault_i(peer_flt),
    .peer_share_i(peer_tx), .share_lvl_o(share_bus_pin_i),
    .permit_lvl_o(standby_permit_line_i), .pg_lvl_o(power_good_flag_i));

  // ==========================================================================
  // clock, watchdog, checking
  initial forever #2.5 sys_clk_i = ~sys_clk_i;
  initial
  begin
    repeat (60000) @(posedge sys_clk_i);
    miscompares++;
    summarize();
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic pick(input int s);
    case (s)
      0: return main_rail_en_o;
      1: return power_good_flag_i;
      2: return line_good_flag_o;
      3: return dcdc_standby_o;
      default: return standby_rail_en_o;
    endcase
  endfunction

  task automatic check(input string n, input logic [33:0] got, exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask

  // bus answers are compared against the oldest note
  always @(posedge sys_clk_i)
  begin
    seed <= lfsr(seed);
    load_current_i <= seed[7:0];
    peer_tx <= seed[8] & peer_on;
    if (s_axi_bvalid && s_axi_bready)
      check("bresp", {s_axi_bresp, 32'h0}, notes.pop_front());
    if (s_axi_rvalid && s_axi_rready)
      check("rdata", {s_axi_rresp, s_axi_rdata}, notes.pop_front());
  end

  task automatic axw(input logic [3:0] a, input logic [31:0] d,
    input logic [1:0] r);
    logic aw, w;
    aw = 0;
    w = 0;
    notes.push_back({r, 32'h0});
    @(posedge sys_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw && w))
    begin
      @(posedge sys_clk_i);
      if (s_axi_awready) aw = 1;
      if (s_axi_wready) w = 1;
      if (aw) s_axi_awvalid <= 0;
      if (w) s_axi_wvalid <= 0;
    end
    while (!s_axi_bvalid) @(posedge sys_clk_i);
    s_axi_bready <= 0;
  endtask

  task automatic axr(input logic [3:0] a, input logic [33:0] e);
    notes.push_back(e);
    @(posedge sys_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge sys_clk_i); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    while (!s_axi_rvalid) @(posedge sys_clk_i);
    s_axi_rready <= 0;
  endtask

  // waits for a level, counting cycles, and checks the ms window
  task automatic win(input string n, input int sel, input logic lv,
    input int lo, input int hi);
    int c;
    c = 0;
    while (pick(sel) !== lv && c <= hi * CPM)
    begin
      @(posedge sys_clk_i);
      c++;
    end
    check(n, 34'(c >= lo * CPM && c <= hi * CPM), 34'h1);
  endtask

  task automatic summarize();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial
  begin
    repeat (8) @(posedge sys_clk_i);
    rst_b_i <= 1;
    axr(CT, 34'h0);
    axr(supply_seq_pkg::STATUS_OFS, 34'h1);
    axr(4'hc, {supply_seq_pkg::RESP_SLVERR, 32'h0});
    axw(4'hc, 32'h1, supply_seq_pkg::RESP_SLVERR);
    line_in_range_i <= 1;
    standby_rail_ok_i <= 1;
    win("standby", 4, 1, 0, 1);
    repeat (30 * CPM) @(posedge sys_clk_i);
    check("main idle", 34'(main_rail_en_o), 34'h0);
    main_output_enable_n_i <= 0;
    win("main on", 0, 1, 10, 250);
    main_rail_above_thr_i <= 1;
    win("pg on", 1, 1, 100, 500);
    win("line good", 2, 1, 0, 500);
    axr(supply_seq_pkg::SHARE_OFS, 34'h10);
    check("master", 34'({share_master_o, share_trim_o}), 34'h10);
    peer_on <= 1;
    load_low_i <= 1;
    axw(CT, 32'h1, supply_seq_pkg::RESP_OKAY);
    axr(CT, 34'h1);
    win("hot standby", 3, 1, 0, 2);
    peer_flt <= 1;
    win("leave standby", 3, 0, 0, 2);
    peer_flt <= 0;
    flt[4] <= 1;
    win("pg drop", 1, 0, 0, 1);
    win("oc main off", 0, 0, 1, 20);
    flt[4] <= 0;
    check("latched", 34'({fault_latched_o, standby_permit_line_oe_n_o,
      share_bus_pin_oe_n_o}), 34'h5);
    main_output_enable_n_i <= 1;
    repeat (10 * CPM) @(posedge sys_clk_i);
    check("cleared", 34'(fault_latched_o), 34'h0);
    line_in_range_i <= 0;
    win("line drop", 2, 0, 0, 5);
    win("standby hold", 4, 0, 15, 40);
    line_in_range_i <= 1;
    win("line dip", 2, 1, 0, 100);
    main_output_enable_n_i <= 0;
    win("main rest", 0, 1, 900, 1100);
    flt[0] <= 1;
    win("kill main off", 0, 0, 0, 1);
    check("kill standby", 34'(standby_rail_en_o), 34'h1);
    summarize();
  end
endmodule
